//--- rtl/lpm_cfg.svh
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define LPM_CTRL_IDX 10'h009
`define LPM_STAT_IDX 10'h00a

// ----------------------------------------
// Control byte fields
// ----------------------------------------
`define LPM_CTRL_RESET 8'h00
`define LPM_BIT_UNUSED 0
`define LPM_BIT_WAKE_ALERT 1
`define LPM_BIT_WAKE_TERM 2
`define LPM_BIT_WAKE_RXD 3
`define LPM_BIT_WAKE_HOSTWR 4
`define LPM_BIT_WAKE_RING 5
`define LPM_BIT_STOP_SEL 6
`define LPM_BIT_ENTRY_EN 7

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define LPM_STAT_STATE_LSB 0
`define LPM_STAT_CAUSE_LSB 2
`define LPM_STAT_STOP_OK 7

`endif

//--- rtl/lpm_pkg.sv
package lpm_pkg;
  typedef enum logic [1:0] {st_run, st_sleep, st_stop, st_resume} lp_state_t;
  typedef logic [4:0] wake_vec_t;
endpackage

//--- rtl/lpm_wake_if.sv
`timescale 1ns/1ps
interface lpm_wake_if;
  lpm_pkg::wake_vec_t enable;
  logic armed;
  lpm_pkg::wake_vec_t hit;
  logic wake;
  modport ctl (output enable, output armed, input hit, input wake);
  modport det (input enable, input armed, output hit, output wake);
endinterface

//--- rtl/wake_detect.sv
`timescale 1ns/1ps
`include "lpm_cfg.svh"
module wake_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Raw pins, active low
  input wire logic port_d_line5,
  input wire logic port_d_line4,
  input wire logic port_a_line2,
  input wire logic port_a_line0,
  // Controller side
  lpm_wake_if.det wk
);

  // ----------------------------------------
  // Two-stage synchronisers
  // ----------------------------------------
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic [3:0] meta_nxt;
  logic [3:0] sync_nxt;
  lpm_pkg::wake_vec_t hit_r;
  lpm_pkg::wake_vec_t hit_nxt;
  logic wake_r;
  logic wake_nxt;

  // Sources, active high once low level seen
  function automatic lpm_pkg::wake_vec_t match(input logic [3:0] lvl);
    lpm_pkg::wake_vec_t v;
    v = 5'h00;
    v[0] = ~lvl[3]; // RQ6
    v[1] = ~lvl[2]; // RQ7
    v[2] = ~lvl[1]; // RQ8
    v[3] = ~lvl[3] & ~lvl[2]; // RQ9
    v[4] = ~lvl[0]; // RQ10
    return v;
  endfunction

  always_comb begin
    meta_nxt = {port_d_line5, port_d_line4, port_a_line2, port_a_line0};
    sync_nxt = meta_r;
    hit_nxt = match(sync_r) & wk.enable; // RQ12
    wake_nxt = wk.armed & (|hit_nxt); // RQ12
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 4'hf;
      sync_r <= 4'hf;
      hit_r <= 5'h00;
      wake_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      hit_r <= hit_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign wk.hit = hit_r;
  assign wk.wake = wake_r;

endmodule // wake_detect

//--- rtl/low_power_mode_control.sv
// Functional notes
// [RQ1] Control byte at index 0009, cleared to zero by reset.
// [RQ2] All control bits read and write; bits 7:6 never read one while halted. Here bit 7 reads one while halted; 7:6 clear only on wake.
// [RQ3] Bit 7 one allows entry when low-power conditions exist; zero blocks it.
// [RQ4] Bit 6 selects stop when one, sleep when zero.
// [RQ5] Without stop support the select is ignored and sleep is entered.
// [RQ6] Bit 1 enables wake on low alert input, port D line 5.
// [RQ7] Bit 2 enables wake on low terminal-ready, port D line 4.
// [RQ8] Bit 3 enables wake on low serial receive, port A line 2.
// [RQ9] Bit 4 enables wake when port D lines 4 and 5 both low.
// [RQ10] Bit 5 enables wake on low ring indicator, port A line 0.
// [RQ11] Bit 0 has no function on entry or exit.
// [RQ12] Level wake works with core clock stopped; processor then resumes.
`timescale 1ns/1ps
`include "lpm_cfg.svh"
module low_power_mode_control #(
  parameter bit STOP_SUPPORTED = 1'b1,
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor core
  input wire logic idle_request,
  output logic cpu_halt,
  output logic core_clock_enable,
  output logic wake_pulse,
  // Low-power state
  output logic sleep_active,
  output logic stop_active,
  // Wake pins, active low
  input wire logic port_d_line5,
  input wire logic port_d_line4,
  input wire logic port_a_line2,
  input wire logic port_a_line0
);

  // ----------------------------------------
  // Address decode helpers
  // ----------------------------------------
  function automatic logic [9:0] word_index(input logic [ADDR_W-1:0] a);
    return 10'(a[ADDR_W-1:2]);
  endfunction

  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
    return (word_index(a) == idx) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic in_low_power(input lpm_pkg::lp_state_t s);
    return (s == lpm_pkg::st_sleep) || (s == lpm_pkg::st_stop);
  endfunction

  // ----------------------------------------
  // Wake carrier
  // ----------------------------------------
  lpm_wake_if wk ();

  // ----------------------------------------
  // Control and state
  // ----------------------------------------
  logic [7:0] low_power_control_r;
  logic [7:0] low_power_control_nxt;
  lpm_pkg::lp_state_t low_power_state_r;
  lpm_pkg::lp_state_t low_power_state_nxt;
  lpm_pkg::wake_vec_t cause_r;
  lpm_pkg::wake_vec_t cause_nxt;

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;

  // ----------------------------------------
  // Core outputs
  // ----------------------------------------
  logic cpu_halt_r;
  logic cpu_halt_nxt;
  logic core_clock_enable_r;
  logic core_clock_enable_nxt;
  logic wake_pulse_r;
  logic wake_pulse_nxt;
  logic sleep_active_r;
  logic sleep_active_nxt;
  logic stop_active_r;
  logic stop_active_nxt;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic setup_phase;
  logic access_done;
  logic hit_ctrl;
  logic hit_stat;
  logic ctrl_write;
  logic low_power_entry_enable;
  logic stop_sleep_select;
  logic enter_lp;
  logic [7:0] status_word;

  // ----------------------------------------
  // Wake detector
  // ----------------------------------------
  // Pins are synchronised inside the detector
  wake_detect u_wake (
    .clk(clk),
    .resetn(resetn),
    .port_d_line5(port_d_line5),
    .port_d_line4(port_d_line4),
    .port_a_line2(port_a_line2),
    .port_a_line0(port_a_line0),
    .wk(wk)
  );

  // Bit 0 has no wake source, so it stays out of the vector
  assign wk.enable = low_power_control_r[`LPM_BIT_WAKE_RING:`LPM_BIT_WAKE_ALERT]; // RQ11
  assign wk.armed = in_low_power(low_power_state_r); // RQ12

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  always_comb begin
    setup_phase = psel & ~penable;
    // Write lands only in the access cycle
    access_done = psel & penable & pready_r;
    hit_ctrl = is_reg(paddr, `LPM_CTRL_IDX); // RQ1
    hit_stat = is_reg(paddr, `LPM_STAT_IDX);
    ctrl_write = access_done & pwrite & hit_ctrl & pstrb[0];
    low_power_entry_enable = low_power_control_r[`LPM_BIT_ENTRY_EN];
    stop_sleep_select = low_power_control_r[`LPM_BIT_STOP_SEL];
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  always_comb begin
    status_word = 8'h00;
    status_word[`LPM_STAT_STATE_LSB +: 2] = low_power_state_r;
    status_word[`LPM_STAT_CAUSE_LSB +: 5] = cause_r;
    status_word[`LPM_STAT_STOP_OK] = STOP_SUPPORTED;
  end

  always_comb begin
    // Registered answer: one access cycle after every setup
    pready_nxt = setup_phase;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    if (setup_phase) begin
      if (hit_ctrl) begin
        prdata_nxt = {24'h00_0000, low_power_control_r}; // RQ2
      end else if (hit_stat) begin
        prdata_nxt = {24'h00_0000, status_word};
        pslverr_nxt = pwrite;
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Control byte
  // ----------------------------------------
  always_comb begin
    low_power_control_nxt = low_power_control_r;
    if (ctrl_write) begin
      low_power_control_nxt = pwdata[7:0]; // RQ2
    end else if (wk.wake) begin
      // Drop enable and select on wake so both read back as zero after resume
      low_power_control_nxt[`LPM_BIT_ENTRY_EN] = 1'b0; // RQ2
      low_power_control_nxt[`LPM_BIT_STOP_SEL] = 1'b0; // RQ2
    end
  end

  // ----------------------------------------
  // Low-power state machine
  // ----------------------------------------
  always_comb begin
    enter_lp = low_power_entry_enable & idle_request; // RQ3
    low_power_state_nxt = low_power_state_r;
    cause_nxt = cause_r;
    case (low_power_state_r)
      lpm_pkg::st_run: begin
        if (enter_lp) begin
          if (stop_sleep_select && STOP_SUPPORTED) begin // RQ4 RQ5
            low_power_state_nxt = lpm_pkg::st_stop;
          end else begin
            low_power_state_nxt = lpm_pkg::st_sleep; // RQ5
          end
        end
      end
      lpm_pkg::st_sleep, lpm_pkg::st_stop: begin
        if (wk.wake) begin
          low_power_state_nxt = lpm_pkg::st_resume; // RQ12
          cause_nxt = wk.hit;
        end
      end
      lpm_pkg::st_resume: begin
        // One halted cycle carries the wake pulse
        low_power_state_nxt = lpm_pkg::st_run; // RQ12
      end
      default: begin
        low_power_state_nxt = lpm_pkg::st_run;
      end
    endcase
  end

  // ----------------------------------------
  // Core-facing outputs
  // ----------------------------------------
  always_comb begin
    sleep_active_nxt = (low_power_state_nxt == lpm_pkg::st_sleep);
    stop_active_nxt = (low_power_state_nxt == lpm_pkg::st_stop);
    cpu_halt_nxt = in_low_power(low_power_state_nxt) |
                   (low_power_state_nxt == lpm_pkg::st_resume); // RQ3
    // Stop gates the core clock; this block keeps running
    core_clock_enable_nxt = ~stop_active_nxt; // RQ12
    wake_pulse_nxt = (low_power_state_nxt == lpm_pkg::st_resume);
  end

  // ----------------------------------------
  // APB answer registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------
  // Control byte register
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_power_control_r <= `LPM_CTRL_RESET; // RQ1
    end else begin
      low_power_control_r <= low_power_control_nxt;
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_power_state_r <= lpm_pkg::st_run;
      cause_r <= 5'h00;
    end else begin
      low_power_state_r <= low_power_state_nxt;
      cause_r <= cause_nxt;
    end
  end

  // ----------------------------------------
  // Core output registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_halt_r <= 1'b0;
      core_clock_enable_r <= 1'b1;
      wake_pulse_r <= 1'b0;
      sleep_active_r <= 1'b0;
      stop_active_r <= 1'b0;
    end else begin
      cpu_halt_r <= cpu_halt_nxt;
      core_clock_enable_r <= core_clock_enable_nxt;
      wake_pulse_r <= wake_pulse_nxt;
      sleep_active_r <= sleep_active_nxt;
      stop_active_r <= stop_active_nxt;
    end
  end

  assign cpu_halt = cpu_halt_r;
  assign core_clock_enable = core_clock_enable_r;
  assign wake_pulse = wake_pulse_r;
  assign sleep_active = sleep_active_r;
  assign stop_active = stop_active_r;

endmodule // low_power_mode_control

//--- dv/lpm_chk.sv
`timescale 1ns/1ps
module lpm_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Core and pins
  input wire logic idle_request,
  input wire logic cpu_halt,
  input wire logic core_clock_enable,
  input wire logic wake_pulse,
  input wire logic sleep_active,
  input wire logic stop_active,
  input wire logic port_d_line5,
  input wire logic port_d_line4,
  input wire logic port_a_line2,
  input wire logic port_a_line0
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic quiet = &{port_d_line5, port_d_line4, port_a_line2, port_a_line0};
  wire logic low_pwr = sleep_active || stop_active;
  sequence exit_s;
    wake_pulse && !low_pwr;
  endsequence
  sequence resume_s;
    !cpu_halt && !wake_pulse;
  endsequence
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  rdata_width_a: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  entry_cause_a: assert property ($rose(low_pwr) |-> $past(idle_request))
    else $error("entry without idle");
  stop_gate_a: assert property (stop_active |-> cpu_halt && !core_clock_enable)
    else $error("stop without gate");
  one_state_a: assert property (sleep_active |-> !stop_active)
    else $error("two states at once");
  wake_exit_a: assert property (wake_pulse |-> exit_s ##1 resume_s)
    else $error("bad wake exit");
  halt_hold_a: assert property (low_pwr |-> cpu_halt)
    else $error("core runs in low power");
  quiet_hold_a: assert property ((quiet && low_pwr) [*6] |=> low_pwr)
    else $error("wake with pins high");
endmodule // lpm_chk
bind low_power_mode_control lpm_chk lpm_chk_inst (.clk(clk), .resetn(resetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .idle_request(idle_request), .cpu_halt(cpu_halt),
  .core_clock_enable(core_clock_enable), .wake_pulse(wake_pulse),
  .sleep_active(sleep_active), .stop_active(stop_active),
  .port_d_line5(port_d_line5), .port_d_line4(port_d_line4),
  .port_a_line2(port_a_line2), .port_a_line0(port_a_line0));

//--- dv/lpm_partner.sv
`timescale 1ns/1ps
module lpm_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bench control
  input wire logic go_idle,
  input wire logic [3:0] pin_low,
  // Device side
  output logic idle_request,
  output logic port_d_line5,
  output logic port_d_line4,
  output logic port_a_line2,
  output logic port_a_line0
);
  // Core reports idle one cycle after the bench asks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_request <= 1'b0;
    end else begin
      idle_request <= go_idle;
    end
  end
  // Pulled-up pins, driven low on request
  assign {port_a_line0, port_a_line2, port_d_line4, port_d_line5} = ~pin_low;
endmodule // lpm_partner

//--- dv/tb_low_power_mode_control.sv
`timescale 1ns/1ps
module tb_low_power_mode_control;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hf;
  logic go_idle = 1'b0;
  logic [3:0] pin_low = 4'h0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, idle_request, cpu_halt, clk_en, wake_pulse;
  wire logic sleep_active, stop_active, d5, d4, a2, a0;
  wire logic [3:0] stv = {stop_active, sleep_active, wake_pulse, cpu_halt};
  int n_fail = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic er;

  initial begin
    forever #20 clk = ~clk;
  end

  low_power_mode_control low_power_mode_control_inst (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_request(idle_request), .cpu_halt(cpu_halt), .core_clock_enable(clk_en),
    .wake_pulse(wake_pulse), .sleep_active(sleep_active), .stop_active(stop_active),
    .port_d_line5(d5), .port_d_line4(d4), .port_a_line2(a2), .port_a_line0(a0));
  lpm_partner lpm_partner_inst (.clk(clk), .resetn(resetn), .go_idle(go_idle),
    .pin_low(pin_low), .idle_request(idle_request), .port_d_line5(d5),
    .port_d_line4(d4), .port_a_line2(a2), .port_a_line0(a0));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int i;
    i = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1);
    chk("pready wait", 32'h1, i);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_bit(input int b, input logic v, input string nm);
    int i;
    for (i = 0; i < 20 && stv[b] !== v; i++) @(negedge clk);
    chk(nm, {31'h0, v}, {31'h0, stv[b]});
  endtask

  task automatic t_regs;
    apb(1'b0, 12'h024, 32'h0, 4'hf);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b1, 12'h024, 32'h3f, 4'hf);
    apb(1'b0, 12'h024, 32'h0, 4'hf);
    chk("ctrl rw", 32'h3f, rd);
    apb(1'b1, 12'h024, 32'h0, 4'h0);
    apb(1'b0, 12'h024, 32'h0, 4'hf);
    chk("strobe off", 32'h3f, rd);
    apb(1'b0, 12'h040, 32'h0, 4'hf);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b0, 12'h028, 32'h0, 4'hf);
    chk("status idle", 32'h80, rd);
    apb(1'b1, 12'h028, 32'hff, 4'hf);
    chk("status write err", 32'h1, {31'h0, er});
    @(posedge clk) go_idle <= 1'b1;
    repeat (10) @(negedge clk);
    chk("entry blocked", 32'h0, {31'h0, cpu_halt});
    @(posedge clk) go_idle <= 1'b0;
  endtask

  // Enter, try a pin set that must not wake, then the one that must
  task automatic t_wake(input logic [7:0] c, input logic [3:0] bad, input logic [3:0] good,
    input logic stop);
    apb(1'b1, 12'h024, {24'h0, c}, 4'hf);
    @(posedge clk) go_idle <= 1'b1;
    wait_bit(0, 1'b1, "halt");
    chk("stop state", {31'h0, stop}, {31'h0, stop_active});
    chk("sleep state", {31'h0, !stop}, {31'h0, sleep_active});
    chk("clock gate", {31'h0, !stop}, {31'h0, clk_en});
    // Quiet pins for a while must not wake
    repeat (8) @(negedge clk);
    @(posedge clk) pin_low <= bad;
    repeat (10) @(negedge clk);
    chk("no wake", 32'h1, {31'h0, cpu_halt});
    @(posedge clk) pin_low <= good;
    wait_bit(1, 1'b1, "wake");
    @(posedge clk) go_idle <= 1'b0;
    pin_low <= 4'h0;
    wait_bit(0, 1'b0, "resume");
    apb(1'b0, 12'h024, 32'h0, 4'hf);
    chk("ctrl after", {26'h0, c[5:0]}, rd);
  endtask

  // Reset in mid-run drops the low-power state and clears the control byte
  task automatic t_reset;
    apb(1'b1, 12'h024, 32'h82, 4'hf);
    @(posedge clk) go_idle <= 1'b1;
    wait_bit(0, 1'b1, "halt before reset");
    @(posedge clk) resetn <= 1'b0;
    go_idle <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk("halt after reset", 32'h0, {31'h0, cpu_halt});
    chk("sleep after reset", 32'h0, {31'h0, sleep_active});
    chk("clock after reset", 32'h1, {31'h0, clk_en});
    apb(1'b0, 12'h024, 32'h0, 4'hf);
    chk("ctrl after reset", 32'h0, rd);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end

  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_wake(8'h82, 4'b1110, 4'b0001, 1'b0);
    t_wake(8'hc4, 4'b1101, 4'b0010, 1'b1);
    t_wake(8'h88, 4'b1011, 4'b0100, 1'b0);
    t_wake(8'hd0, 4'b0010, 4'b0011, 1'b1);
    t_wake(8'ha0, 4'b0111, 4'b1000, 1'b0);
    t_wake(8'hc3, 4'b1110, 4'b0011, 1'b1);
    t_reset;
    report_and_stop;
  end
endmodule // tb_low_power_mode_control
